// ===== hdl/chpsc_pkg.sv
// Purpose: constants for the channel pin status and control block
// Assumes: one 20 MHz clock, synchronous active-low reset
// Notes: analog levels arrive as digital indications from the front end
// Notes on behaviour
// - reset drives high-speed transmit to differential zero
// - reset drives low-speed outputs to differential zero
// - indicator reads 0 detected, 1 lost
// - lost below 75 mV, found above 150 mV
// - management selects function shown on indicator
// - reset drives the indicator pin low
// - power-down pin low floats the indicator
// - register power-down also floats the indicator
// - each jog edge rotates low-speed output lanes once
// - power-down pin low enters power-down mode
package chpsc_pkg;
  localparam int unsigned LANES = 8;
  localparam int unsigned LANE_W = 3;
  localparam int unsigned LOS_ASSERT_MV = 75;
  localparam int unsigned LOS_DEASSERT_MV = 150;
  localparam int unsigned SEL_W = 2;
  localparam logic [1:0] SEL_LOS = 2'h0;
  localparam logic [1:0] SEL_LOCK = 2'h1;
  localparam logic [1:0] SEL_ROT = 2'h2;
  localparam logic [1:0] SEL_PDN = 2'h3;
  localparam logic [2:0] ROT_RESET = 3'h0;
  localparam logic STATUS_RESET = 1'b0;
  typedef enum logic [1:0] {CHPSC_RESET, CHPSC_RUN, CHPSC_PDN} chpsc_state_t;
endpackage

// ===== hdl/chpsc_top.sv
// Purpose: pin-level control and status for one serial channel
// Assumes: inputs synchronous to clk except the jog pin, which is synchronised
// Notes: differential pairs are modelled as true/complement digital levels
`timescale 1ns/1ns
module chpsc_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tx_data_bit,
  input wire logic [7:0] ls_lane_data,
  input wire logic rx_swing_low,
  input wire logic rx_swing_high,
  input wire logic los_enable,
  input wire logic reg_powerdown,
  input wire logic [1:0] obs_select,
  input wire logic pll_lock,
  input wire logic chan_powerdown_low,
  input wire logic lane_rotate_jog,
  output logic hs_tx_out_pos,
  output logic hs_tx_out_neg,
  output logic [7:0] ls_lane_outputs_pos,
  output logic [7:0] ls_lane_outputs_neg,
  output logic loss_of_signal_ind_o,
  output logic loss_of_signal_ind_oe,
  output logic [2:0] lane_rot_ff,
  output logic rotate_pulse_ff,
  output logic powered_down_ff,
  output logic multi_status_out
);
  chpsc_pkg::chpsc_state_t state_ff;
  logic jog_s1_ff, jog_s2_ff, jog_last_ff;
  logic los_ff;
  logic pdn;

  assign pdn = !chan_powerdown_low || reg_powerdown;

  // mode tracking: reset, running, powered down
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= chpsc_pkg::CHPSC_RESET;
    end else if (pdn) begin
      state_ff <= chpsc_pkg::CHPSC_PDN;
    end else begin
      state_ff <= chpsc_pkg::CHPSC_RUN;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      powered_down_ff <= 1'b0;
    end else begin
      powered_down_ff <= pdn;
    end
  end

  // high-speed transmit pair; zero differential while in reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hs_tx_out_pos <= 1'b0;
      hs_tx_out_neg <= 1'b0;
    end else begin
      hs_tx_out_pos <= tx_data_bit;
      hs_tx_out_neg <= !tx_data_bit;
    end
  end

  // low-speed output pairs, rotated lane order
  genvar gi;
  generate
    for (gi = 0; gi < chpsc_pkg::LANES; gi++) begin : g_lane
      logic [2:0] src;
      assign src = 3'(gi) + lane_rot_ff;
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          ls_lane_outputs_pos[gi] <= 1'b0;
          ls_lane_outputs_neg[gi] <= 1'b0;
        end else begin
          ls_lane_outputs_pos[gi] <= ls_lane_data[src];
          ls_lane_outputs_neg[gi] <= !ls_lane_data[src];
        end
      end
    end
  endgenerate

  // loss-of-signal with hysteresis between the two swing thresholds
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      los_ff <= 1'b1;
    end else if (!los_enable) begin
      los_ff <= 1'b0;
    end else if (rx_swing_low) begin
      los_ff <= 1'b1;
    end else if (rx_swing_high) begin
      los_ff <= 1'b0;
    end
  end

  // indicator pin: low in reset, floating in power-down, else selected function
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      loss_of_signal_ind_o <= 1'b0;
      loss_of_signal_ind_oe <= 1'b1;
    end else if (pdn) begin
      loss_of_signal_ind_o <= 1'b0;
      loss_of_signal_ind_oe <= 1'b0;
    end else begin
      loss_of_signal_ind_oe <= 1'b1;
      unique case (obs_select)
        chpsc_pkg::SEL_LOS: loss_of_signal_ind_o <= los_ff;
        chpsc_pkg::SEL_LOCK: loss_of_signal_ind_o <= pll_lock;
        chpsc_pkg::SEL_ROT: loss_of_signal_ind_o <= rotate_pulse_ff;
        chpsc_pkg::SEL_PDN: loss_of_signal_ind_o <= lane_rot_ff[0];
      endcase
    end
  end

  // jog synchroniser and edge detect; the chain keeps tracking the pin in reset,
  // so a pin left high across reset gives no false rotation (reset spans 3 cycles)
  always_ff @(posedge clk) begin
    jog_s1_ff <= lane_rotate_jog;
    jog_s2_ff <= jog_s1_ff;
    jog_last_ff <= jog_s2_ff;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rotate_pulse_ff <= 1'b0;
      lane_rot_ff <= chpsc_pkg::ROT_RESET;
    end else begin
      rotate_pulse_ff <= jog_s2_ff ^ jog_last_ff;
      if (jog_s2_ff ^ jog_last_ff) begin
        lane_rot_ff <= lane_rot_ff + 3'h1;
      end
    end
  end

  // reserved status output held at a fixed level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      multi_status_out <= chpsc_pkg::STATUS_RESET;
    end else begin
      multi_status_out <= chpsc_pkg::STATUS_RESET;
    end
  end

  property p_tx_reset;
    @(posedge clk) !rst_n |=> (!hs_tx_out_pos && !hs_tx_out_neg);
  endproperty
  a_tx_reset: assert property (p_tx_reset) else $error("tx not zero after reset");

  property p_ls_reset;
    @(posedge clk) !rst_n |=> (ls_lane_outputs_pos == 8'h00 && ls_lane_outputs_neg == 8'h00);
  endproperty
  a_ls_reset: assert property (p_ls_reset) else $error("ls outputs not zero");

  property p_ind_reset;
    @(posedge clk) !rst_n |=> (loss_of_signal_ind_oe && !loss_of_signal_ind_o);
  endproperty
  a_ind_reset: assert property (p_ind_reset) else $error("indicator not low in reset");

  property p_pin_pdn;
    @(posedge clk) disable iff (!rst_n) !chan_powerdown_low |=> !loss_of_signal_ind_oe;
  endproperty
  a_pin_pdn: assert property (p_pin_pdn) else $error("indicator driven in pin pdn");

  property p_reg_pdn;
    @(posedge clk) disable iff (!rst_n) reg_powerdown |=> !loss_of_signal_ind_oe;
  endproperty
  a_reg_pdn: assert property (p_reg_pdn) else $error("indicator driven in reg pdn");

  property p_los_set;
    @(posedge clk) disable iff (!rst_n) (los_enable && rx_swing_low) |=> los_ff;
  endproperty
  a_los_set: assert property (p_los_set) else $error("los not set on low swing");

  property p_los_show;
    @(posedge clk) disable iff (!rst_n)
      (!pdn && obs_select == chpsc_pkg::SEL_LOS) |=> (loss_of_signal_ind_o == $past(los_ff));
  endproperty
  a_los_show: assert property (p_los_show) else $error("indicator not showing los");

  property p_lock_show;
    @(posedge clk) disable iff (!rst_n)
      (!pdn && obs_select == chpsc_pkg::SEL_LOCK)
      |=> (loss_of_signal_ind_o == $past(pll_lock));
  endproperty
  a_lock_show: assert property (p_lock_show) else $error("indicator not showing lock");

  property p_rot_show;
    @(posedge clk) disable iff (!rst_n)
      (!pdn && obs_select == chpsc_pkg::SEL_ROT)
      |=> (loss_of_signal_ind_o == $past(rotate_pulse_ff));
  endproperty
  a_rot_show: assert property (p_rot_show) else $error("indicator not showing pulse");

  property p_drive_run;
    @(posedge clk) disable iff (!rst_n) !pdn |=> loss_of_signal_ind_oe;
  endproperty
  a_drive_run: assert property (p_drive_run) else $error("indicator not driven");

  property p_pd_flag;
    @(posedge clk) disable iff (!rst_n) pdn |=> powered_down_ff;
  endproperty
  a_pd_flag: assert property (p_pd_flag) else $error("power-down flag missing");

  property p_jog_once;
    @(posedge clk) disable iff (!rst_n) rotate_pulse_ff |=> !rotate_pulse_ff;
  endproperty
  a_jog_once: assert property (p_jog_once) else $error("rotate pulse too long");

  property p_rotate;
    @(posedge clk) disable iff (!rst_n)
      $changed(jog_s2_ff) |=> (lane_rot_ff == $past(lane_rot_ff) + 3'h1);
  endproperty
  a_rotate: assert property (p_rotate) else $error("lane rotation missed");

  property p_pdn_mode;
    @(posedge clk) disable iff (!rst_n) !chan_powerdown_low |=> state_ff == chpsc_pkg::CHPSC_PDN;
  endproperty
  a_pdn_mode: assert property (p_pdn_mode) else $error("pdn mode not entered");

  c_rotate: cover property (@(posedge clk) disable iff (!rst_n) rotate_pulse_ff);
  c_los: cover property (@(posedge clk) disable iff (!rst_n) los_ff ##[1:20] !los_ff);
  c_pdn: cover property (@(posedge clk) disable iff (!rst_n) !loss_of_signal_ind_oe);
  c_sel_rot: cover property (@(posedge clk) disable iff (!rst_n)
    obs_select == chpsc_pkg::SEL_ROT && loss_of_signal_ind_o);
endmodule

// ===== verif/chpsc_jog_model.sv
// Purpose: board-side control that works the lane rotation jog pin
// Assumes: one request pulse on go per wanted rotation
// Notes: requests are spaced at least two cycles apart by the bench
`timescale 1ns/1ns
module chpsc_jog_model (
  input wire logic clk,
  input wire logic go,
  output logic lane_rotate_jog
);
  logic level_ff = 1'b0;
  // one level change per request, rising and falling alike
  always @(posedge clk) begin
    if (go) begin
      level_ff <= ~level_ff;
    end
  end
  assign lane_rotate_jog = level_ff;
  // multi_status_out is never looked at from the board side
endmodule

// ===== verif/test_chpsc_top.sv
// Purpose: self-checking bench for the channel pin status block
// Assumes: 20 MHz clock, synchronous active-low reset
// Notes: table rows cover transmit, loss indication and observation
`timescale 1ns/1ns
module test_chpsc_top;
  logic clk, rst_n, tx, swl, swh, en, rpd, lock, pdn_n, go;
  logic [1:0] sel;
  logic [7:0] lsd, lp, ln;
  logic tp, tn, io, ioe, pul, pd, ms, jog;
  logic [2:0] rot;
  int n_fail, n_tests, cyc;
  logic [7:0] np, ni;
  // row: tx, swing low, swing high, enable, select, lock | indicator | tx pair
  logic [9:0] rows [8] = '{10'h346, 10'h0c1, 10'h242, 10'h101, 10'h25e, 10'h051,
                           10'h3c6, 10'h045};
  chpsc_top DUT (.clk(clk), .rst_n(rst_n), .tx_data_bit(tx), .ls_lane_data(lsd),
    .rx_swing_low(swl), .rx_swing_high(swh), .los_enable(en), .reg_powerdown(rpd),
    .obs_select(sel), .pll_lock(lock), .chan_powerdown_low(pdn_n),
    .lane_rotate_jog(jog), .hs_tx_out_pos(tp), .hs_tx_out_neg(tn),
    .ls_lane_outputs_pos(lp), .ls_lane_outputs_neg(ln), .loss_of_signal_ind_o(io),
    .loss_of_signal_ind_oe(ioe), .lane_rot_ff(rot), .rotate_pulse_ff(pul),
    .powered_down_ff(pd), .multi_status_out(ms));
  chpsc_jog_model board (.clk(clk), .go(go), .lane_rotate_jog(jog));
  // clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // compare one value
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // counts and verdict
  task print_verdict;
    $display("tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 400) begin
      n_fail++;
      print_verdict;
    end
  end
  function automatic logic [7:0] rotr(logic [7:0] v, int r);
    return (v >> r) | (v << (8 - r));
  endfunction
  // main sequence
  initial begin
    {rst_n, tx, swl, swh, en, rpd, lock, go, sel} = '0;
    pdn_n = 1'b1;
    lsd = 8'ha5;
    tx = 1'b1;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk({tp, tn}, 8'h0);
    chk(lp, 8'h0);
    chk(ln, 8'h0);
    chk({io, ioe}, 8'h1);
    foreach (rows[i]) begin
      @(posedge clk);
      {tx, swl, swh, en, sel, lock} <= rows[i][9:3];
      repeat (3) @(posedge clk);
      #1;
      chk(io, rows[i][2]);
      chk({tp, tn}, rows[i][1:0]);
    end
    chk(lp, lsd);
    // jog edges; first pass shows the pulse, later passes the rotation bit
    for (int k = 1; k < 4; k++) begin
      @(posedge clk);
      go <= 1'b1;
      sel <= (k == 1) ? chpsc_pkg::SEL_ROT : chpsc_pkg::SEL_PDN;
      @(posedge clk);
      go <= 1'b0;
      np = 8'h00;
      ni = 8'h00;
      repeat (6) begin
        @(posedge clk);
        #1;
        np += pul;
        ni += io;
      end
      chk(np, 8'h01);
      if (k == 1) begin
        chk(ni, 8'h01);
      end else begin
        chk(io, 8'(k % 2));
      end
      chk(rot, 8'(k));
      chk(lp, rotr(lsd, k));
      chk(ln, ~rotr(lsd, k));
    end
    // pin power-down, then register power-down
    @(posedge clk);
    pdn_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(ioe, 1'b0);
    chk(pd, 1'b1);
    @(posedge clk);
    pdn_n <= 1'b1;
    rpd <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(ioe, 1'b0);
    // leave power-down with a datapath reset while the jog pin rests high
    @(posedge clk);
    rpd <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({io, ioe, tp, tn}, 8'h04);
    chk(ln, 8'h00);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk(rot, 8'h00);
    chk(lp, lsd);
    chk(pd, 1'b0);
    chk({ioe, ms}, 8'h2);
    print_verdict;
  end
endmodule
